/* File: inc/sft_pkg.sv */
// constants and types of the scheduler feedback table writer
package sft_pkg;
	// register byte offsets
	localparam logic [7:0] OFF_CONFIG = 8'h00;
	localparam logic [7:0] OFF_BASE   = 8'h04;
	localparam logic [7:0] OFF_UPDATE = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0c;
	localparam logic [7:0] OFF_MASK   = 8'h10;
	localparam logic [7:0] OFF_LPSEL  = 8'h14;
	localparam logic [7:0] OFF_IDENT  = 8'h18;
	localparam logic [7:0] OFF_LPCNT  = 8'h1c;
	localparam logic [7:0] OFF_TSLO   = 8'h20;
	localparam logic [7:0] OFF_TSHI   = 8'h24;
	// config fields
	localparam int CFG_SUP_LSB = 0;
	localparam int CFG_CLS_LSB = 8;
	localparam int CFG_EN_BIT  = 16;
	// update fields
	localparam int UPD_VAL_LSB = 0;
	localparam int UPD_CLS_LSB = 8;
	localparam int UPD_CAP_LSB = 16;
	localparam int UPD_FRC_BIT = 19;
	// status and mask bits
	localparam int ST_DONE_BIT = 0;
	localparam int ST_REF_BIT  = 1;
	// reset values: two capabilities, one class
	localparam logic [7:0]  RST_SUPPORT = 8'h03;
	localparam logic [7:0]  RST_CLASSES = 8'h01;
	localparam logic [15:0] RST_LPCNT   = 16'h0004;
	// table layout
	localparam logic [31:0] HDR_FIXED  = 32'h0000_0008;
	localparam logic [31:0] HDR_MIN    = 32'h0000_0010;
	localparam logic [11:0] ALIGN_MASK = 12'h007;
	localparam logic [2:0]  TS_LAST    = 3'h7;
	localparam logic [7:0]  FLAG_CHG   = 8'h01;
	localparam logic [7:0]  FLAG_IDLE  = 8'h02;
	// crystal time base
	localparam int CLK_PERIOD_NS  = 25;
	localparam int XTAL_PERIOD_NS = 100;
	localparam int XTAL_DIV_INT   = XTAL_PERIOD_NS / CLK_PERIOD_NS;
	localparam logic [7:0] XTAL_DIV = 8'(XTAL_DIV_INT);
	typedef enum logic [1:0] {ST_IDLE, ST_CAP, ST_FLAG, ST_STAMP} sft_state_t;
endpackage

/* File: logic/sft_writer.sv */
// scheduler feedback table writer with ahb-lite registers
`timescale 1ns/1ps
module sft_writer
	import sft_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	output logic             mem_wr,
	output logic      [31:0] mem_addr,
	output logic      [7:0]  mem_data,
	output logic             irq
);
	// register state
	logic [7:0]  support_reg;
	logic [7:0]  classes_reg;
	logic        enable_reg;
	logic [31:0] base_reg;
	logic [15:0] lpcnt_reg;
	logic [15:0] lpsel_reg;
	logic [1:0]  status_reg;
	logic [1:0]  status_next;
	logic [1:0]  mask_reg;
	logic [63:0] ts_reg;
	logic [63:0] snap_reg;
	logic [7:0]  div_reg;
	// latched update request
	logic [7:0]  val_reg;
	logic [7:0]  cls_reg;
	logic [2:0]  cap_reg;
	logic        force_reg;
	logic [15:0] lp_reg;
	logic [2:0]  byte_reg;
	sft_state_t  state_reg;
	// ahb data-phase bookkeeping
	logic        wr_pend_reg;
	logic [7:0]  wr_addr_reg;

	// address phase decode, and write strobes from the latched data-phase address
	wire         ahb_go  = hsel & htrans[1] & hready;
	wire         rd_go   = ahb_go & ~hwrite;
	wire         wr_go   = ahb_go & hwrite;
	wire [7:0]   a_off   = haddr[7:0];
	wire         wr_cfg  = wr_pend_reg & (wr_addr_reg == OFF_CONFIG);
	wire         wr_base = wr_pend_reg & (wr_addr_reg == OFF_BASE);
	wire         wr_upd  = wr_pend_reg & (wr_addr_reg == OFF_UPDATE);
	wire         wr_stat = wr_pend_reg & (wr_addr_reg == OFF_STATUS);
	wire         wr_mask = wr_pend_reg & (wr_addr_reg == OFF_MASK);
	wire         wr_sel  = wr_pend_reg & (wr_addr_reg == OFF_LPSEL);
	wire         wr_cnt  = wr_pend_reg & (wr_addr_reg == OFF_LPCNT);

	// capability count is the number of enumerated support bits
	logic [3:0] cap_cnt;
	always_comb begin
		cap_cnt = 4'h0;
		for (int b = 0; b < 8; b++) begin
			cap_cnt = cap_cnt + {3'h0, support_reg[b]};
		end
	end

	// layout arithmetic, all indices zero based
	wire [11:0] row_w    = {8'h0, cap_cnt} * {4'h0, classes_reg};
	wire [11:0] stride_w = (row_w + ALIGN_MASK) & ~ALIGN_MASK;
	wire [31:0] hdr_w    = HDR_FIXED + {20'h0, stride_w};
	wire [31:0] sub_w    = ({28'h0, cap_cnt} * {24'h0, cls_reg}) + {29'h0, cap_reg};
	wire [31:0] flag_off = HDR_FIXED + sub_w;
	wire [31:0] lp_off   = 32'(({16'h0, lp_reg} + 32'h1) * {20'h0, stride_w});
	wire [31:0] ent_off  = HDR_FIXED + lp_off + sub_w;

	// request fields seen with the data phase
	wire [7:0]  u_cls = hwdata[UPD_CLS_LSB +: 8];
	wire [2:0]  u_cap = hwdata[UPD_CAP_LSB +: 3];
	// capability indices at or beyond the enumerated count have no slot, so they are refused
	wire        u_ok  = enable_reg & (state_reg == ST_IDLE)
		& (u_cls < classes_reg) & ({1'b0, u_cap} < cap_cnt)
		& (lpsel_reg < lpcnt_reg);
	wire        u_acc = wr_upd & u_ok;
	wire        done  = (state_reg == ST_STAMP) & (byte_reg == TS_LAST);

	// read mux, unmapped offsets read zero
	logic [31:0] rd_w;
	always_comb begin
		case (a_off)
			OFF_CONFIG: rd_w = {15'h0, enable_reg, classes_reg, support_reg};
			OFF_BASE:   rd_w = base_reg;
			OFF_STATUS: rd_w = {30'h0, status_reg};
			OFF_MASK:   rd_w = {30'h0, mask_reg};
			OFF_LPSEL:  rd_w = {16'h0, lpsel_reg};
			OFF_IDENT:  rd_w = {lpsel_reg, classes_reg, support_reg};
			OFF_LPCNT:  rd_w = {16'h0, lpcnt_reg};
			OFF_TSLO:   rd_w = ts_reg[31:0];
			OFF_TSHI:   rd_w = ts_reg[63:32];
			default:    rd_w = 32'h0;
		endcase
	end

	// events win over a same-cycle write-one clear
	always_comb begin
		status_next = status_reg;
		if (wr_stat) begin
			status_next = status_next & ~hwdata[1:0];
		end
		if (done) begin
			status_next[ST_DONE_BIT] = 1'b1;
		end
		if (wr_upd & ~u_ok) begin
			status_next[ST_REF_BIT] = 1'b1;
		end
	end

	// bus slave: zero wait, read data captured in address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata      <= 32'h0;
			hreadyout   <= 1'b1;
			hresp       <= 1'b0;
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h0;
		end else begin
			wr_pend_reg <= wr_go;
			if (wr_go) begin
				wr_addr_reg <= a_off;
			end
			if (rd_go) begin
				hrdata <= rd_w;
			end
		end
	end

	// software-written configuration
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			support_reg <= RST_SUPPORT;
			classes_reg <= RST_CLASSES;
			enable_reg  <= 1'b0;
			base_reg    <= 32'h0;
			lpcnt_reg   <= RST_LPCNT;
			lpsel_reg   <= 16'h0;
			mask_reg    <= 2'h0;
		end else begin
			if (wr_cfg) begin
				support_reg <= hwdata[CFG_SUP_LSB +: 8];
				classes_reg <= hwdata[CFG_CLS_LSB +: 8];
				enable_reg  <= hwdata[CFG_EN_BIT];
			end
			if (wr_base) begin
				base_reg <= hwdata;
			end
			if (wr_cnt) begin
				lpcnt_reg <= hwdata[15:0];
			end
			if (wr_sel) begin
				lpsel_reg <= hwdata[15:0];
			end
			if (wr_mask) begin
				mask_reg <= hwdata[1:0];
			end
		end
	end

	// status and level interrupt
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status_reg <= 2'h0;
			irq        <= 1'b0;
		end else begin
			status_reg <= status_next;
			irq        <= |(status_next & mask_reg);
		end
	end

	// crystal time base from a divider enable
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_reg <= 8'h0;
			ts_reg  <= 64'h0;
		end else if (div_reg == XTAL_DIV - 8'h1) begin
			div_reg <= 8'h0;
			ts_reg  <= ts_reg + 64'h1;
		end else begin
			div_reg <= div_reg + 8'h1;
		end
	end

	// update sequencer: data byte, then flag, then timestamp
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= ST_IDLE;
			val_reg   <= 8'h0;
			cls_reg   <= 8'h0;
			cap_reg   <= 3'h0;
			force_reg <= 1'b0;
			lp_reg    <= 16'h0;
			byte_reg  <= 3'h0;
			snap_reg  <= 64'h0;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (u_acc) begin
						val_reg   <= hwdata[UPD_VAL_LSB +: 8];
						cls_reg   <= u_cls;
						cap_reg   <= u_cap;
						force_reg <= hwdata[UPD_FRC_BIT];
						lp_reg    <= lpsel_reg;
						state_reg <= ST_CAP;
					end
				end
				ST_CAP: begin
					state_reg <= ST_FLAG;
				end
				ST_FLAG: begin
					snap_reg  <= ts_reg;
					byte_reg  <= 3'h0;
					state_reg <= ST_STAMP;
				end
				ST_STAMP: begin
					byte_reg <= byte_reg + 3'h1;
					if (byte_reg == TS_LAST) begin
						state_reg <= ST_IDLE;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// memory byte write port, one byte per cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mem_wr   <= 1'b0;
			mem_addr <= 32'h0;
			mem_data <= 8'h0;
		end else begin
			mem_wr <= state_reg != ST_IDLE;
			case (state_reg)
				ST_CAP: begin
					mem_addr <= base_reg + ent_off;
					mem_data <= val_reg;
				end
				ST_FLAG: begin
					mem_addr <= base_reg + flag_off;
					mem_data <= FLAG_CHG | (force_reg ? FLAG_IDLE : 8'h0);
				end
				ST_STAMP: begin
					mem_addr <= base_reg + {29'h0, byte_reg};
					mem_data <= snap_reg[{byte_reg, 3'h0} +: 8];
				end
				default: begin
					mem_addr <= mem_addr;
					mem_data <= mem_data;
				end
			endcase
		end
	end

	// checks
	property p_order;
		@(posedge hclk) disable iff (!hresetn)
		(state_reg == ST_CAP) |=> (state_reg == ST_FLAG) ##1 (state_reg == ST_STAMP);
	endproperty
	a_order: assert property (p_order) else $error("order broken");

	property p_cap_addr;
		@(posedge hclk) disable iff (!hresetn)
		(state_reg == ST_CAP) |=> mem_wr && (mem_addr == base_reg + ent_off) && (mem_data == val_reg);
	endproperty
	a_cap_addr: assert property (p_cap_addr) else $error("entry byte wrong");

	property p_flag;
		@(posedge hclk) disable iff (!hresetn)
		(state_reg == ST_FLAG) |=> mem_wr && (mem_addr == base_reg + flag_off) && mem_data[0];
	endproperty
	a_flag: assert property (p_flag) else $error("flag byte wrong");

	property p_force;
		@(posedge hclk) disable iff (!hresetn)
		(state_reg == ST_FLAG) |=> (mem_data[1] == $past(force_reg));
	endproperty
	a_force: assert property (p_force) else $error("idle bit wrong");

	property p_stamp;
		@(posedge hclk) disable iff (!hresetn)
		(state_reg == ST_FLAG) |=> (state_reg == ST_STAMP)[*8] ##1 (state_reg == ST_IDLE);
	endproperty
	a_stamp: assert property (p_stamp) else $error("stamp length wrong");

	property p_pad;
		@(posedge hclk) disable iff (!hresetn)
		(stride_w[2:0] == 3'h0) && (stride_w >= row_w) && (stride_w - row_w < 12'h8);
	endproperty
	a_pad: assert property (p_pad) else $error("padding wrong");

	property p_hdr;
		@(posedge hclk) disable iff (!hresetn)
		(row_w != 12'h0) |-> (hdr_w >= HDR_MIN);
	endproperty
	a_hdr: assert property (p_hdr) else $error("header too small");

	property p_lp;
		@(posedge hclk) disable iff (!hresetn)
		(state_reg == ST_CAP) |-> (lp_reg < lpcnt_reg);
	endproperty
	a_lp: assert property (p_lp) else $error("entry beyond count");

	property p_ident;
		@(posedge hclk) disable iff (!hresetn)
		(rd_go && a_off == OFF_IDENT && !wr_sel) |=> (hrdata[31:16] == lpsel_reg);
	endproperty
	a_ident: assert property (p_ident) else $error("ident index wrong");
endmodule

/* File: test/sft_os_model.sv */
// scheduler-side memory holding the feedback table
`timescale 1ns/1ps
module sft_os_model (
	input wire logic        hclk,
	input wire logic        mem_wr,
	input wire logic [31:0] mem_addr,
	input wire logic [7:0]  mem_data
);
	logic [7:0]  mem [logic [31:0]];
	logic [31:0] wr_log [$];

	// unwritten bytes read as zero: table zeroed before enable
	function automatic logic [7:0] rdb(input logic [31:0] a);
		return mem.exists(a) ? mem[a] : 8'h00;
	endfunction

	// memory takes every byte, no back-pressure
	always @(posedge hclk) begin
		if (mem_wr === 1'b1) begin
			mem[mem_addr] = mem_data;
			wr_log.push_back(mem_addr);
		end
	end
endmodule

/* File: test/test_scheduler_feedback_table_writer.sv */
// register-level testbench of the table writer
`timescale 1ns/1ps
module test_scheduler_feedback_table_writer
	import sft_pkg::*;
;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, mem_addr, rdv, ts0;
	logic [1:0]  htrans = 0;
	logic [2:0]  hsize = 3'h2;
	logic        hreadyout, hresp, mem_wr, irq, msk;
	logic [7:0]  mem_data;
	int          miscompares = 0, cmp_count = 0;

	always #12.5 hclk = ~hclk;

	sft_writer i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .mem_wr(mem_wr), .mem_addr(mem_addr),
		.mem_data(mem_data), .irq(irq));
	sft_os_model i_os (.hclk(hclk), .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_data(mem_data));

	task results();
		if (miscompares == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			$display("[ERR] %s expected %h seen %h", nm, e, g);
			miscompares++;
		end
	endtask

	// one edge with hready high, bounded
	task rdy();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 100);
		if (hreadyout !== 1'b1) begin
			$display("[ERR] hready expected 1 seen %b", hreadyout);
			miscompares++;
			results();
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		hsel <= 1; haddr <= {24'h0, a}; htrans <= 2'h2; hwrite <= 1;
		rdy();
		hsel <= 0; htrans <= 2'h0; hwdata <= d;
		rdy();
	endtask

	task rd(input logic [7:0] a);
		hsel <= 1; haddr <= {24'h0, a}; htrans <= 2'h2; hwrite <= 0;
		rdy();
		hsel <= 0; htrans <= 2'h0;
		rdy();
		rdv = hrdata;
	endtask

	// update request, wait for done or refusal, then clear status
	task upd(input logic [15:0] lp, input logic [7:0] cls, input logic [2:0] cap, input logic [7:0] v,
		input logic f, input logic [31:0] est);
		int n;
		wr(OFF_LPSEL, {16'h0, lp});
		i_os.wr_log.delete();
		wr(OFF_UPDATE, {12'h0, f, cap, cls, v});
		n = 0;
		rdv = 0;
		while (rdv[1:0] == 2'h0 && n < 50) begin
			rd(OFF_STATUS);
			n++;
		end
		chk("status", est, rdv);
		// status never came: bound used up, stop here
		if (rdv[1:0] == 2'h0) begin
			results();
		end
		chk("irq", {31'h0, est[0] & msk}, {31'h0, irq});
		wr(OFF_STATUS, 32'h3);
		@(posedge hclk);
		chk("irq_clr", 32'h0, {31'h0, irq});
	endtask

	initial begin
		msk = 0;
		repeat (2) @(posedge hclk);
		hresetn <= 1;
		@(posedge hclk);
		rd(OFF_CONFIG); chk("config", 32'h0000_0103, rdv);
		rd(OFF_LPCNT); chk("lpcnt", 32'h0000_0004, rdv);
		rd(8'h40); chk("unmapped", 32'h0, rdv);
		upd(16'h0, 8'h0, 3'h0, 8'h11, 1'b0, 32'h2);
		// three of eight capabilities, three classes: stride 16
		wr(OFF_BASE, 32'h0000_1000);
		wr(OFF_CONFIG, 32'h0001_030b);
		wr(OFF_MASK, 32'h1);
		msk = 1;
		upd(16'h3, 8'h2, 3'h2, 8'hff, 1'b1, 32'h1);
		chk("n_writes", 32'd10, i_os.wr_log.size());
		chk("first", 32'h1050, i_os.wr_log[0]);
		chk("second", 32'h1010, i_os.wr_log[1]);
		chk("ts0", 32'h1000, i_os.wr_log[2]);
		chk("ts7", 32'h1007, i_os.wr_log[9]);
		chk("entry", 32'hff, {24'h0, i_os.rdb(32'h1050)});
		chk("flag", 32'h03, {24'h0, i_os.rdb(32'h1010)});
		rd(OFF_IDENT); chk("ident", 32'h0003_030b, rdv);
		upd(16'h0, 8'h3, 3'h0, 8'h01, 1'b0, 32'h2);
		upd(16'h0, 8'h0, 3'h3, 8'h01, 1'b0, 32'h2);
		upd(16'h4, 8'h0, 3'h0, 8'h01, 1'b0, 32'h2);
		chk("no_writes", 32'd0, i_os.wr_log.size());
		// legacy two capabilities, one class, masked
		wr(OFF_MASK, 32'h0);
		msk = 0;
		wr(OFF_CONFIG, 32'h0001_0103);
		upd(16'h0, 8'h0, 3'h1, 8'h00, 1'b0, 32'h1);
		chk("leg_entry", 32'h1011, i_os.wr_log[0]);
		chk("leg_flag", 32'h1009, i_os.wr_log[1]);
		chk("leg_fval", 32'h01, {24'h0, i_os.rdb(32'h1009)});
		chk("hresp", 32'h0, {31'h0, hresp});
		// crystal counter: two reads forty clocks apart
		rd(OFF_TSHI); chk("ts_hi", 32'h0, rdv);
		rd(OFF_TSLO); ts0 = rdv;
		repeat (38) @(posedge hclk);
		rd(OFF_TSLO); chk("ts_rate", ts0 + 32'(40 / XTAL_DIV_INT), rdv);
		results();
	end
endmodule
